//--- design/tick_flag_pkg.sv
// Constants for the tick flag and restart control block.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package tick_flag_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_HZ        = 100_000_000;   // System clock rate
  localparam int unsigned TICK_MS       = 125;           // Tick period in ms
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;  // Cycles per tick
  localparam int unsigned DIV_W         = 24;            // Divider counter width
  localparam logic [23:0] DIV_RESET     = 24'h000000;    // Divider after reset
  localparam logic        FLAG_RESET    = 1'b0;          // Flag after power-up
  localparam logic        ARMED_RESET   = 1'b0;          // Setting disabled after power-up
  localparam logic        PIN_RESET     = 1'b0;          // Synchroniser stages after reset
  localparam logic        RESTART_RESET = 1'b0;          // Restart pulse after reset
  localparam logic [1:0]  BOOT_CYCLES   = 2'h2;          // Forced-run cycles after power-up

  // Core run state
  typedef enum logic [1:0] {
    RUN_ST     = 2'b00,  // Core executing
    HALT_ST    = 2'b01,  // Run-enable low or clock halted
    WAIT_ST    = 2'b10   // Run-enable high, waiting for flag set
  } run_state_e;
endpackage

//--- design/tick_divider.sv
// Free-running divider making the periodic tick pulse.
// Assumes one clock domain; runs whenever reset is released.
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned PERIOD = tick_flag_pkg::TICK_CYCLES   // Cycles per tick
) (
  input  wire logic clk,    // System clock
  input  wire logic rstn,   // Async reset, active low
  output logic      tick    // One-cycle tick pulse
);
  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Final count, cut to the counter width on purpose
  localparam int unsigned LAST_I = PERIOD - 1;
  localparam logic [tick_flag_pkg::DIV_W-1:0] LAST = LAST_I[tick_flag_pkg::DIV_W-1:0];

  logic [tick_flag_pkg::DIV_W-1:0] cnt_q;   // Cycle count
  logic [tick_flag_pkg::DIV_W-1:0] cnt_d;   // Next count
  wire                             wrap_w;  // Last cycle of period

  assign wrap_w = (cnt_q == LAST);
  assign cnt_d  = wrap_w ? '0 : cnt_q + 1'b1;
  assign tick   = wrap_w;

  // Counter keeps running regardless of core state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= tick_flag_pkg::DIV_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Tick is exactly one cycle wide
  tick_single_a: assert property (@(posedge clk) disable iff (!rstn)
    tick |=> !tick) else $error("tick wider than one cycle");
endmodule

//--- design/tick_flag_ctrl.sv
// Tick flag, power-fail detect and restart control for a small core.
// Assumes run_en is an asynchronous pin; test and halt strobes come
// from the core on the same clock. rstn stands for the supply rise.
`timescale 1ns/1ps
module tick_flag_ctrl #(
  parameter int unsigned TICK_PERIOD = tick_flag_pkg::TICK_CYCLES  // Cycles per tick
) (
  input  wire logic clk,          // System clock, 100 MHz
  input  wire logic rstn,         // Power-up reset, active low
  input  wire logic run_en,       // Run-enable pin, async
  input  wire logic test_op,      // Timer flag test op executes
  input  wire logic halt_op,      // Clock halt op executes
  output logic      test_result,  // Test result, valid with test_op
  output logic      timer_flag,   // Current flag state
  output logic      core_run,     // Core may execute
  output logic      restart       // One-cycle: load address zero
);
  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic run_meta_q;   // First stage, read only by second
  logic run_sync_q;   // Synchronised run-enable
  logic run_prev_q;   // Previous synchronised value
  wire  run_rise_w;   // Low-to-high change of run-enable

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_meta_q <= tick_flag_pkg::PIN_RESET;   // Pin taken as low until sampled
      run_sync_q <= tick_flag_pkg::PIN_RESET;
      run_prev_q <= tick_flag_pkg::PIN_RESET;
    end else begin
      run_meta_q <= run_en;
      run_sync_q <= run_meta_q;
      run_prev_q <= run_sync_q;
    end
  end
  assign run_rise_w = run_sync_q & ~run_prev_q;

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  wire tick_w;   // 8 Hz tick pulse

  tick_divider #(
    .PERIOD (TICK_PERIOD)
  ) u_div (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_w)
  );

  // ---------------------------------------------------------------
  // Timer flag
  // ---------------------------------------------------------------
  logic flag_q;    // Timer flag
  logic flag_d;    // Next flag
  logic armed_q;   // Set by first test; enables tick setting
  wire  set_w;     // Tick may set the flag

  // Setting is blocked until software has tested once
  assign set_w  = tick_w & armed_q;
  // Test wins over a coincident tick so the flag ends clear;
  // a set flag just stays set, so extra ticks are dropped.
  assign flag_d = test_op ? 1'b0 :
                  (set_w ? 1'b1 : flag_q);
  // A coincident tick counts as set in the result
  assign test_result = flag_q | (test_op & set_w);
  assign timer_flag  = flag_q;
  // The flag is one bit: software that tests less often than once per
  // tick period loses time, since missed ticks are counted nowhere.
  // Arming is never undone until the next power-up.

  // Power-up clears the flag and disarms setting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q  <= tick_flag_pkg::FLAG_RESET;
      armed_q <= tick_flag_pkg::ARMED_RESET;
    end else begin
      flag_q  <= flag_d;
      armed_q <= armed_q | test_op;
    end
  end

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  tick_flag_pkg::run_state_e state_q;   // Run state
  tick_flag_pkg::run_state_e state_d;   // Next run state
  logic [1:0]                boot_cnt_q;   // Forced-run cycles left after power-up
  logic [1:0]                boot_cnt_d;   // Next forced-run count
  wire                       boot_w;       // Inside the power-up start
  wire                       boot_first_w; // First cycle after power-up
  wire                       go_w;         // Flag being set this cycle

  // The synchroniser leaves reset low whatever the pin shows. The core is
  // held in run until both stages carry the real pin level; otherwise a
  // high pin would read as a fall and halt the core right after power-up.
  assign boot_w       = (boot_cnt_q != 2'h0);
  assign boot_first_w = (boot_cnt_q == tick_flag_pkg::BOOT_CYCLES);
  assign boot_cnt_d   = boot_w ? (boot_cnt_q - 2'h1) : 2'h0;

  // Restart waits for a tick that really sets the flag;
  // a test in the same cycle swallows it and the wait goes on.
  assign go_w = set_w & ~test_op;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tick_flag_pkg::RUN_ST: begin
        // Halt op or run-enable low stops the core
        if (halt_op || !run_sync_q) begin
          state_d = tick_flag_pkg::HALT_ST;
        end
      end
      tick_flag_pkg::HALT_ST: begin
        // Rising run-enable arms the restart
        if (run_rise_w) begin
          state_d = tick_flag_pkg::WAIT_ST;
        end
      end
      tick_flag_pkg::WAIT_ST: begin
        if (!run_sync_q) begin
          state_d = tick_flag_pkg::HALT_ST;
        end else if (go_w) begin
          state_d = tick_flag_pkg::RUN_ST;
        end
      end
      default: begin
        state_d = tick_flag_pkg::HALT_ST;
      end
    endcase
  end

  // Power-up starts at zero at once whatever run-enable shows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= tick_flag_pkg::RUN_ST;
      boot_cnt_q <= tick_flag_pkg::BOOT_CYCLES;
    end else begin
      // Forced run while the count runs down; it then rests at zero
      state_q    <= boot_w ? tick_flag_pkg::RUN_ST : state_d;
      boot_cnt_q <= boot_cnt_d;
    end
  end

  // Restart is a one-cycle pulse at power-up or on the set tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      restart <= tick_flag_pkg::RESTART_RESET;
    end else begin
      // Power-up pulse comes from the first forced-run cycle only
      restart <= boot_first_w |
                 ((state_q == tick_flag_pkg::WAIT_ST) & run_sync_q & go_w);
    end
  end

  // Core runs only in run state; halted otherwise
  assign core_run = (state_q == tick_flag_pkg::RUN_ST);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Flag set, clear and test result
  flag_set_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    (set_w && !test_op) |=> flag_q)
    else $error("tick did not set flag");
  flag_clear_test_a: assert property (@(posedge clk) disable iff (!rstn)
    test_op |=> !flag_q)
    else $error("test did not clear flag");
  only_test_clears_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(flag_q) |-> $past(test_op))
    else $error("flag cleared without test");
  result_matches_a: assert property (@(posedge clk) disable iff (!rstn)
    (test_op && !tick_w) |-> (test_result == flag_q))
    else $error("test result differs from flag");

  // Arming and lost ticks
  unarmed_no_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (!armed_q && !flag_q) |=> !flag_q)
    else $error("flag set before first test");
  set_flag_holds_a: assert property (@(posedge clk) disable iff (!rstn)
    (flag_q && !test_op) |=> flag_q)
    else $error("set flag dropped by tick");

  // Restart and run control
  restart_flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (restart && !$past(boot_w)) |-> flag_q)
    else $error("restart without flag set");
  restart_go_a: assert property (@(posedge clk) disable iff (!rstn)
    ((state_q == tick_flag_pkg::WAIT_ST) && run_sync_q && go_w)
    |=> (restart && core_run && flag_q))
    else $error("set tick did not restart core");
  restart_single_a: assert property (@(posedge clk) disable iff (!rstn)
    restart |=> !restart)
    else $error("restart wider than one cycle");
  halt_stops_core_a: assert property (@(posedge clk) disable iff (!rstn)
    (core_run && halt_op && !boot_w) |=> !core_run)
    else $error("halt op did not stop core");
  runlow_halts_a: assert property (@(posedge clk) disable iff (!rstn)
    (!run_sync_q && !boot_w) |=> !core_run)
    else $error("core runs with run-enable low");
  wait_runlow_a: assert property (@(posedge clk) disable iff (!rstn)
    ((state_q == tick_flag_pkg::WAIT_ST) && !run_sync_q)
    |=> (state_q == tick_flag_pkg::HALT_ST))
    else $error("wait not left on run-enable low");

  // Power-up start
  boot_runs_a: assert property (@(posedge clk) disable iff (!rstn)
    boot_w |=> core_run)
    else $error("core not running during power-up start");

  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  // Main scenarios: coincident test, set-tick restart, aborted wait
  test_tick_c: cover property (@(posedge clk) disable iff (!rstn) test_op && set_w);
  backed_restart_c: cover property (@(posedge clk) disable iff (!rstn)
    restart && !$past(boot_w));
  halt_wait_c: cover property (@(posedge clk) disable iff (!rstn)
    state_q == tick_flag_pkg::WAIT_ST);
  wait_abort_c: cover property (@(posedge clk) disable iff (!rstn)
    (state_q == tick_flag_pkg::WAIT_ST) && !run_sync_q);
  halt_op_c: cover property (@(posedge clk) disable iff (!rstn) core_run && halt_op);
endmodule

//--- dv/tick_flag_power_fail_detect_test.sv
// Self-checking bench for the tick flag and restart control block.
// Assumes tick_flag_ctrl with a short tick period; no partner model.
`timescale 1ns/1ps
module tick_flag_power_fail_detect_test;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  localparam int unsigned PER = 20;  // Short tick period for sim
  logic clk;                         // System clock
  logic rstn;                        // Supply-rise reset
  logic run_en;                      // Run-enable pin
  logic test_op;                     // Test op strobe
  logic halt_op;                     // Halt op strobe
  logic test_result;                 // Test answer
  logic timer_flag;                  // Flag state
  logic core_run;                    // Core runs
  logic restart;                     // Load address zero
  int   mismatches;                  // Failed compares
  int   checked;                     // All compares
  `define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, act, exp); end end
  tick_flag_ctrl #(.TICK_PERIOD(PER)) u_dut (.clk(clk), .rstn(rstn), .run_en(run_en),
    .test_op(test_op), .halt_op(halt_op), .test_result(test_result),
    .timer_flag(timer_flag), .core_run(core_run), .restart(restart));
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Step to just after the next edge, where inputs change
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for flag (sel 0) or restart (sel 1); a timeout ends the run
  task automatic wait_for(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      step();
      if ((sel == 0) ? (timer_flag === 1'b1) : (restart === 1'b1)) return;
    end
    mismatches++;
    test_done();
  endtask
  // One test op; answer looked at within its own cycle
  task automatic do_test(input logic exp);
    test_op = 1'b1;
    #1;
    `CHK(test_result, exp)
    step();
    test_op = 1'b0;
    `CHK(timer_flag, 1'b0)
  endtask
  // Supply rise with a chosen run-enable level
  task automatic power_up(input logic en);
    rstn = 1'b0;
    run_en = en;
    repeat (3) step();
    `CHK({timer_flag, core_run, restart}, 3'h2)
    rstn = 1'b1;
    step();
    `CHK({restart, timer_flag}, 2'h2)
    step();
    `CHK(restart, 1'b0)
    step();
    `CHK(core_run, en)
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Ticks before the first test leave the flag clear
  task automatic unarmed();
    repeat (PER + 10) step();
    `CHK(timer_flag, 1'b0)
    do_test(1'b0);
  endtask
  // Tick sets; nothing but the test clears; extra ticks lost
  task automatic tick_set();
    wait_for(0, PER + 5);
    repeat (2 * PER + 5) step();
    `CHK(timer_flag, 1'b1)
    do_test(1'b1);
  endtask
  // Test on the tick cycle wins: answer set, flag ends clear
  task automatic coincident();
    wait_for(0, PER + 5);
    do_test(1'b1);
    repeat (PER - 2) @(posedge clk);
    #1;
    do_test(1'b1);
  endtask
  // Backed-up restart waits for the next set tick
  task automatic backed_restart();
    run_en = 1'b0;
    repeat (5) step();
    `CHK(core_run, 1'b0)
    run_en = 1'b1;
    wait_for(1, PER + 10);
    `CHK({timer_flag, core_run}, 2'h3)
    do_test(1'b1);
  endtask
  // Halt op, then run-enable rise, restarts on the next set tick even with the flag already set
  task automatic halt_restart();
    halt_op = 1'b1;
    step();
    halt_op = 1'b0;
    `CHK(core_run, 1'b0)
    run_en = 1'b0;
    repeat (4) step();
    run_en = 1'b1;
    repeat (5) step();
    run_en = 1'b0;  // Drop while waiting, across a tick: back to halt
    repeat (PER + 5) step();
    `CHK({core_run, restart, timer_flag}, 3'h1)
    run_en = 1'b1;
    wait_for(1, PER + 10);
    `CHK({timer_flag, core_run}, 2'h3)
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    checked = 0;
    rstn = 1'b0;
    run_en = 1'b1;
    test_op = 1'b0;
    halt_op = 1'b0;
    #1;
    power_up(1'b1);
    unarmed();
    tick_set();
    coincident();
    backed_restart();
    halt_restart();
    power_up(1'b0);  // Restart at zero even with run-enable low
    test_done();
  end
endmodule
